// File: hw/hmw_pkg.sv
// constants, register map and state encoding for the halt/wake controller
`default_nettype none
package hmw_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_PRESCALER   = 8'h49;
	localparam logic [7:0]  IDX_CTRL_STATUS = 8'h4A;
	localparam int unsigned APB_AW          = 12;
	localparam logic [11:0] ADDR_PRESCALER  = {2'b00, IDX_PRESCALER, 2'b00};
	localparam logic [11:0] ADDR_CTRL_STAT  = {2'b00, IDX_CTRL_STATUS, 2'b00};
	// control/status field positions
	localparam int unsigned CSR_ENABLE_BIT  = 0;
	localparam int unsigned CSR_MEASURE_BIT = 1;
	localparam int unsigned CSR_FLAG_BIT    = 2;
	// reset values
	localparam logic [7:0]  PRESCALER_RST   = 8'hFF;
	localparam logic [7:0]  PRESCALER_ZERO  = 8'h00;
	localparam logic        CSR_BIT_RST     = 1'b0;
	// timing counts, in clk_sys cycles and rc ticks
	localparam int unsigned STAB_CYCLES     = 256;
	localparam logic [7:0]  STAB_LAST       = 8'(STAB_CYCLES - 1);
	localparam int unsigned RC_FIXED_DIV    = 64;
	localparam logic [5:0]  RC_DIV_LAST     = 6'(RC_FIXED_DIV - 1);
	// low-power controller states
	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_HALT   = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_AWU    = 3'b011,
		ST_STAB   = 3'b100
	} hmw_state_e;
endpackage : hmw_pkg
`default_nettype wire

// File: hw/hmw_awu_if.sv
// link between the controller and the rc wake timer
`timescale 1ns/10ps
`default_nettype none
interface hmw_awu_if;
	logic       run;       // timer counts while high
	logic [7:0] prescaler; // dividing factor
	logic       rc_tick;   // one rc oscillator period
	logic       done;      // delay elapsed, one-cycle pulse
	modport ctrl  (output run, output prescaler, output rc_tick, input done);
	modport timer (input run, input prescaler, input rc_tick, output done);
endinterface : hmw_awu_if
`default_nettype wire

// File: hw/hmw_awu_timer.sv
// rc wake timer: start-up wait, fixed divide by 64, then prescaler
`timescale 1ns/10ps
`default_nettype none
module hmw_awu_timer
	import hmw_pkg::*;
#(
	parameter int unsigned RC_START_TICKS = 4 // rc start-up, in rc ticks
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	hmw_awu_if.timer  awu
);
	localparam logic [7:0] START_LAST = 8'(RC_START_TICKS);

	logic [7:0] start_q;  // start-up ticks seen
	logic [5:0] div_q;    // fixed divider
	logic [7:0] pre_q;    // prescaler count
	logic       fired_q;  // one wake per run
	logic       started;
	logic       div_wrap;
	logic       pre_hit;

	assign started  = (start_q == START_LAST);
	assign div_wrap = started && awu.rc_tick && (div_q == RC_DIV_LAST);
	assign pre_hit  = div_wrap && ((pre_q + 8'h01) >= awu.prescaler);
	assign awu.done = pre_hit && !fired_q && awu.run;

	// counters restart whenever run drops, so each halt gets a full delay
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			start_q <= 8'h00;
			div_q   <= 6'h00;
			pre_q   <= 8'h00;
			fired_q <= 1'b0;
		end else if (!awu.run) begin
			start_q <= 8'h00;
			div_q   <= 6'h00;
			pre_q   <= 8'h00;
			fired_q <= 1'b0;
		end else if (!started) begin
			if (awu.rc_tick) begin
				start_q <= start_q + 8'h01;
			end
		end else if (awu.rc_tick) begin
			div_q <= div_q + 6'h01;
			if (div_wrap) begin
				pre_q <= pre_q + 8'h01;
			end
			if (pre_hit) begin
				fired_q <= 1'b1;
			end
		end
	end
endmodule : hmw_awu_timer
`default_nettype wire

// File: hw/hmw_halt_ctrl.sv
// halt, timed halt and auto-wakeup halt controller with apb registers
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - plain halt when no timed halt, no auto-wake
// - plain halt exit waits 256 cycles, then resumes
// - entering plain halt clears interrupt mask
// - plain halt stops oscillator and peripheral clocks
// - halt with watchdog may give watchdog reset
// - timed halt selected from timer enable bits
// - timed halt reset exit waits 256 cycles
// - timed halt interrupt exit resumes at once
// - entering timed halt clears interrupt mask
// - timed halt keeps oscillator and timer running
// - timed halt enabled never gives watchdog reset
// - auto-wake enable selects auto-wake halt
// - rc clock through divider, prescaler sets flag
// - auto-wake event restarts oscillator, waits 256
// - reading control/status clears flag and interrupt
// - measure bit routes rc to capture
// - auto-wake halt exits on reset or interrupt
// - auto-wake halt keeps oscillator and peripherals off
// - interrupt entry pushes and masks, pop restores
// - delay is 64 times prescaler plus start-up
// - prescaler zero forbidden, else factor equals value
// - software writes leave wake flag unchanged
// - prescaler resets to all ones
module hmw_halt_ctrl
	import hmw_pkg::*;
#(
	parameter int unsigned RC_START_TICKS = 4
) (
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [hmw_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      halt_instr,
	input  wire logic                      watchdog_active,
	input  wire logic                      watchdog_halt_option,
	input  wire logic                      timebase_irq_enable,
	input  wire logic                      overflow_irq_enable,
	input  wire logic                      timer_select_bit2,
	input  wire logic                      timer_clock_select0,
	input  wire logic                      halt_wake_irq,
	input  wire logic                      active_wake_irq,
	input  wire logic                      wake_reset,
	input  wire logic                      cc_pop,
	input  wire logic                      cc_pop_mask,
	input  wire logic                      rc_tick,
	output logic                           main_osc_en,
	output logic                           periph_clk_en,
	output logic                           timer_clk_en,
	output logic                           rc_osc_en,
	output logic                           capture_in,
	output logic                           cpu_run,
	output logic                           irq_mask,
	output logic                           cc_push,
	output logic                           service_irq,
	output logic                           fetch_reset_vec,
	output logic                           watchdog_reset,
	output logic                           auto_wake_irq,
	output logic                           auto_wake_halt_state
);
	import hmw_pkg::*;

	hmw_awu_if awu ();   // link to the rc wake timer

	hmw_state_e state_q, state_d;   // controller state
	logic [7:0] stab_cnt_q, stab_cnt_d; // stabilisation counter
	logic       cause_rst_q, cause_rst_d; // wake came from reset
	logic [7:0] prescaler_q;        // auto_wake_prescaler
	logic       wake_en_q;          // auto_wake_enable
	logic       measure_q;          // auto_wake_measure
	logic       flag_q;             // auto_wake_flag
	logic       i_mask_q;           // condition_code_register mask bit
	logic [31:0] prdata_q;          // read data latched at setup
	logic       svc_q, svc_d;       // service pulse
	logic       fetch_q, fetch_d;   // reset vector pulse
	logic       wdg_q, wdg_d;       // watchdog reset pulse
	logic       enter_halt;         // any halt state entered

	// apb decode
	wire sel_pre   = (paddr == ADDR_PRESCALER);
	wire sel_csr   = (paddr == ADDR_CTRL_STAT);
	wire mapped    = sel_pre || sel_csr;
	wire setup     = psel && !penable;
	wire access    = psel && penable;
	wire wr_pre    = access && pwrite && sel_pre;
	wire wr_csr    = access && pwrite && sel_csr;
	wire rd_csr    = access && !pwrite && sel_csr;
	wire [7:0] csr_val = {5'b00000, flag_q, measure_q, wake_en_q};
	wire [31:0] rd_mux = sel_pre ? {24'h000000, prescaler_q} :
		sel_csr ? {24'h000000, csr_val} : 32'h00000000;

	// timed halt selection from the timer configuration bits
	wire active_sel = timebase_irq_enable ||
		(overflow_irq_enable && !timer_select_bit2 &&
		timer_clock_select0);
	// the watchdog only resets when timed halt is not selected
	wire wdg_trip = watchdog_active && watchdog_halt_option &&
		!active_sel;
	wire halt_go  = (state_q == ST_RUN) && halt_instr;
	wire stab_end = (state_q == ST_STAB) && (stab_cnt_q == STAB_LAST);

	assign pready  = 1'b1;       // always single-cycle access
	assign pslverr = access && !mapped;
	assign prdata  = prdata_q;

	// next-state logic
	always_comb begin
		state_d     = state_q;
		stab_cnt_d  = stab_cnt_q;
		cause_rst_d = cause_rst_q;
		svc_d       = 1'b0;
		fetch_d     = 1'b0;
		wdg_d       = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (halt_go && wdg_trip) begin
					wdg_d = 1'b1;
				end else if (halt_go && wake_en_q) begin
					state_d = ST_AWU;
				end else if (halt_go && active_sel) begin
					state_d = ST_ACTIVE;
				end else if (halt_go) begin
					state_d = ST_HALT;
				end
			end
			ST_HALT, ST_AWU: begin
				// any wake restarts the oscillator, then waits
				if (wake_reset || halt_wake_irq || awu.done) begin
					state_d     = ST_STAB;
					stab_cnt_d  = 8'h00;
					cause_rst_d = wake_reset;
				end
			end
			ST_ACTIVE: begin
				if (wake_reset) begin
					state_d     = ST_STAB;
					stab_cnt_d  = 8'h00;
					cause_rst_d = 1'b1;
				end else if (active_wake_irq || halt_wake_irq) begin
					state_d = ST_RUN;
					svc_d   = 1'b1;
				end
			end
			ST_STAB: begin
				stab_cnt_d = stab_cnt_q + 8'h01;
				if (stab_end) begin
					state_d = ST_RUN;
					svc_d   = !cause_rst_q;
					fetch_d = cause_rst_q;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	assign enter_halt = halt_go && !wdg_trip;

	// state and pulse registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= ST_RUN;
			stab_cnt_q  <= 8'h00;
			cause_rst_q <= 1'b0;
			svc_q       <= 1'b0;
			fetch_q     <= 1'b0;
			wdg_q       <= 1'b0;
		end else begin
			state_q     <= state_d;
			stab_cnt_q  <= stab_cnt_d;
			cause_rst_q <= cause_rst_d;
			svc_q       <= svc_d;
			fetch_q     <= fetch_d;
			wdg_q       <= wdg_d;
		end
	end

	// interrupt mask: cleared on halt entry, set on service, restored on pop
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			i_mask_q <= 1'b1;
		end else if (enter_halt) begin
			i_mask_q <= 1'b0;
		end else if (svc_q) begin
			i_mask_q <= 1'b1;
		end else if (cc_pop) begin
			i_mask_q <= cc_pop_mask;
		end
	end

	// software registers; zero prescaler writes are dropped
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prescaler_q <= PRESCALER_RST;
			wake_en_q   <= CSR_BIT_RST;
			measure_q   <= CSR_BIT_RST;
		end else begin
			if (wr_pre && (pwdata[7:0] != PRESCALER_ZERO)) begin
				prescaler_q <= pwdata[7:0];
			end
			if (wr_csr) begin
				wake_en_q <= pwdata[CSR_ENABLE_BIT];
				measure_q <= pwdata[CSR_MEASURE_BIT];
			end
		end
	end

	// wake flag: set by the timer, cleared by a read, set wins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= CSR_BIT_RST;
		end else if (awu.done) begin
			flag_q <= 1'b1;
		end else if (rd_csr) begin
			flag_q <= 1'b0;
		end
	end

	// read data is captured in the setup phase so it is a flop output
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= 32'h00000000;
		end else if (setup) begin
			prdata_q <= rd_mux;
		end
	end

	// timer runs only inside auto-wake halt
	assign awu.run       = (state_q == ST_AWU);
	assign awu.prescaler = prescaler_q;
	assign awu.rc_tick   = rc_tick;

	hmw_awu_timer #(
		.RC_START_TICKS(RC_START_TICKS)
	) hmw_awu_timer_i (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.awu     (awu.timer)
	);

	// clock gating per state
	wire in_run = (state_q == ST_RUN);
	assign main_osc_en   = (state_q != ST_HALT) &&
		(state_q != ST_AWU);
	assign periph_clk_en = in_run;
	assign timer_clk_en  = in_run ||
		(state_q == ST_ACTIVE);
	assign rc_osc_en     = awu.run || (measure_q && in_run);
	assign capture_in    = measure_q && in_run && rc_tick;
	assign cpu_run       = in_run;
	assign irq_mask      = i_mask_q;
	assign cc_push       = svc_q;
	assign service_irq   = svc_q;
	assign fetch_reset_vec = fetch_q;
	assign watchdog_reset  = wdg_q;
	assign auto_wake_irq   = flag_q;
	assign auto_wake_halt_state = awu.run;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_plain_entry;
		halt_go && !wdg_trip && !wake_en_q && !active_sel
			|=> state_q == ST_HALT && !i_mask_q;
	endproperty
	a_plain_entry: assert property (p_plain_entry)
		else $error("plain halt not entered");

	property p_stab_len;
		$rose(state_q == ST_STAB) |-> ##255 (state_q == ST_STAB)
			##1 (state_q == ST_RUN && (svc_q || fetch_q));
	endproperty
	a_stab_len: assert property (p_stab_len)
		else $error("stabilisation is not 256 cycles");

	property p_halt_clocks;
		state_q == ST_HALT |-> !main_osc_en && !periph_clk_en;
	endproperty
	a_halt_clocks: assert property (p_halt_clocks)
		else $error("clocks running in plain halt");

	property p_wdg;
		halt_go && watchdog_active && watchdog_halt_option
			|=> watchdog_reset == !$past(active_sel);
	endproperty
	a_wdg: assert property (p_wdg)
		else $error("watchdog reset decision wrong");

	property p_active_irq;
		state_q == ST_ACTIVE && active_wake_irq && !wake_reset
			|=> service_irq && cpu_run;
	endproperty
	a_active_irq: assert property (p_active_irq)
		else $error("timed halt interrupt not serviced at once");

	property p_active_clocks;
		state_q == ST_ACTIVE |-> main_osc_en && timer_clk_en
			&& !periph_clk_en;
	endproperty
	a_active_clocks: assert property (p_active_clocks)
		else $error("timed halt clock gating wrong");

	property p_flag_clear;
		rd_csr && !awu.done |=> !flag_q && !auto_wake_irq;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("wake flag not cleared by read");

	property p_awu_prio;
		halt_go && !wdg_trip && wake_en_q |=> state_q == ST_AWU;
	endproperty
	a_awu_prio: assert property (p_awu_prio)
		else $error("auto-wake halt not chosen");

	property p_awu_wake;
		state_q == ST_AWU && awu.done && !wake_reset
			|=> flag_q && state_q == ST_STAB && !main_osc_en == 1'b0;
	endproperty
	a_awu_wake: assert property (p_awu_wake)
		else $error("auto-wake event not handled");

	// service entry masks interrupts unless a new halt clears the mask
	property p_svc_mask;
		svc_q && !enter_halt |=> irq_mask;
	endproperty
	a_svc_mask: assert property (p_svc_mask)
		else $error("mask not set for interrupt service");

	// the pop at the end of a routine gives back the saved mask
	property p_pop_mask;
		cc_pop && !svc_q && !enter_halt |=> irq_mask == $past(cc_pop_mask);
	endproperty
	a_pop_mask: assert property (p_pop_mask)
		else $error("mask not restored by pop");

	c_awu_cycle: cover property (state_q == ST_AWU ##[1:1000] svc_q);
	c_active_wake: cover property (state_q == ST_ACTIVE ##1 svc_q);
	c_reset_wake: cover property (fetch_q);
endmodule : hmw_halt_ctrl
`default_nettype wire

// File: bench/hmw_cpu_model.sv
// partner model: rc wake oscillator ticks and the cpu's flag pop
`timescale 1ns/10ps
`default_nettype none
module hmw_cpu_model #(
	parameter int unsigned RC_PER = 4 // clk_sys cycles per rc period
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic rc_osc_en,
	input  wire logic service_irq,
	output logic      rc_tick,
	output logic      cc_pop,
	output logic      cc_pop_mask
);
	int unsigned rc_cnt;  // position inside one rc period
	int unsigned isr_cnt; // cycles left in the modelled routine
	// the routine was entered from halt with the mask clear, so pop gives 0
	assign cc_pop_mask = 1'b0;
	// rc oscillator: stands still while disabled, like the real one
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rc_cnt  <= 0;
			rc_tick <= 1'b0;
		end else if (rc_osc_en) begin
			rc_cnt  <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
			rc_tick <= (rc_cnt == RC_PER - 1);
		end else begin
			rc_cnt  <= 0;
			rc_tick <= 1'b0;
		end
	end
	// a short interrupt routine ends with a pop of the saved flags
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			isr_cnt <= 0;
			cc_pop  <= 1'b0;
		end else begin
			cc_pop  <= (isr_cnt == 1);
			isr_cnt <= service_irq ? 4 : (isr_cnt > 0 ? isr_cnt - 1 : 0);
		end
	end
endmodule : hmw_cpu_model
`default_nettype wire

// File: bench/tb_halt_mode_wakeup_controller.sv
// self-checking bench for the halt and wake controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
	error_cnt++; \
	$display("unexpected %s: expected %0h, seen %0h", nm, exp, got); end end
module tb_halt_mode_wakeup_controller;
	import hmw_pkg::*;
	localparam int RC_PER = 4; // clk_sys cycles per rc tick
	logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic        halt_instr, watchdog_active, watchdog_halt_option;
	logic        timebase_irq_enable, overflow_irq_enable;
	logic        timer_select_bit2, timer_clock_select0;
	logic        halt_wake_irq, active_wake_irq, wake_reset;
	logic        cc_pop, cc_pop_mask, rc_tick, main_osc_en, periph_clk_en;
	logic        timer_clk_en, rc_osc_en, capture_in, cpu_run, irq_mask;
	logic        cc_push, service_irq, fetch_reset_vec, watchdog_reset;
	logic        auto_wake_irq, auto_wake_halt_state, err_seen;
	int          error_cnt, n_tests, cyc;
	hmw_halt_ctrl #(.RC_START_TICKS(1)) hmw_halt_ctrl_i (
		.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_instr(halt_instr),
		.watchdog_active(watchdog_active),
		.watchdog_halt_option(watchdog_halt_option),
		.timebase_irq_enable(timebase_irq_enable),
		.overflow_irq_enable(overflow_irq_enable),
		.timer_select_bit2(timer_select_bit2),
		.timer_clock_select0(timer_clock_select0),
		.halt_wake_irq(halt_wake_irq), .active_wake_irq(active_wake_irq),
		.wake_reset(wake_reset), .cc_pop(cc_pop), .cc_pop_mask(cc_pop_mask),
		.rc_tick(rc_tick), .main_osc_en(main_osc_en),
		.periph_clk_en(periph_clk_en), .timer_clk_en(timer_clk_en),
		.rc_osc_en(rc_osc_en), .capture_in(capture_in), .cpu_run(cpu_run),
		.irq_mask(irq_mask), .cc_push(cc_push), .service_irq(service_irq),
		.fetch_reset_vec(fetch_reset_vec), .watchdog_reset(watchdog_reset),
		.auto_wake_irq(auto_wake_irq),
		.auto_wake_halt_state(auto_wake_halt_state)
	);
	hmw_cpu_model #(.RC_PER(RC_PER)) hmw_cpu_model_i (
		.clk_sys(clk_sys), .reset_n(reset_n), .rc_osc_en(rc_osc_en),
		.service_irq(service_irq), .rc_tick(rc_tick), .cc_pop(cc_pop),
		.cc_pop_mask(cc_pop_mask)
	);
	// 50 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task results;
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int i;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) begin
			error_cnt++;
			results();
		end
		rd       = prdata;
		err_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// which design output a bounded wait watches
	localparam int W_RUN   = 0; // cpu_run
	localparam int W_FLAG  = 1; // auto_wake_irq
	localparam int W_FETCH = 2; // fetch_reset_vec
	function automatic logic pick(input int w);
		case (w)
			W_RUN:   pick = cpu_run;
			W_FLAG:  pick = auto_wake_irq;
			default: pick = fetch_reset_vec;
		endcase
	endfunction : pick
	// bounded wait for a design output to go high, counting cycles
	task automatic wait_hi(input int w, input int lim, output int n);
		n = 0;
		while (pick(w) !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (pick(w) !== 1'b1) begin
			error_cnt++;
			results();
		end
	endtask : wait_hi
	// one-cycle halt instruction, returns once its effect has landed
	task do_halt;
		@(posedge clk_sys);
		halt_instr <= 1'b1;
		@(posedge clk_sys);
		halt_instr <= 1'b0;
		#1;
	endtask : do_halt
	// main sequence
	initial begin
		{psel, penable, pwrite, halt_instr, watchdog_active} = '0;
		{watchdog_halt_option, timebase_irq_enable, overflow_irq_enable} = '0;
		{timer_select_bit2, timer_clock_select0, halt_wake_irq} = '0;
		{active_wake_irq, wake_reset, reset_n} = '0;
		paddr  = '0;
		pwdata = '0;
		error_cnt = 0;
		n_tests   = 0;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		// register reset values, refused writes, unmapped place
		apb(1'b0, ADDR_PRESCALER, 32'h0, d);
		`CHK("prescaler reset", 32'h000000FF, d)
		apb(1'b1, ADDR_PRESCALER, 32'h0, d);
		apb(1'b0, ADDR_PRESCALER, 32'h0, d);
		`CHK("prescaler after zero", 32'h000000FF, d)
		apb(1'b1, ADDR_CTRL_STAT, 32'h00000004, d);
		apb(1'b0, ADDR_CTRL_STAT, 32'h0, d);
		`CHK("flag after write", 32'h00000000, d)
		apb(1'b0, 12'h000, 32'h0, d);
		`CHK("unmapped error", 1'b1, err_seen)
		// plain halt, watchdog on but option off, woken by interrupt
		watchdog_active <= 1'b1;
		do_halt();
		`CHK("plain cpu", 1'b0, cpu_run)
		`CHK("plain mask", 1'b0, irq_mask)
		`CHK("plain osc", 1'b0, main_osc_en)
		`CHK("plain periph", 1'b0, periph_clk_en)
		@(posedge clk_sys);
		halt_wake_irq <= 1'b1;
		wait_hi(W_RUN, 400, cyc);
		`CHK("plain delay", 1'b1, cyc >= 256 && cyc <= 259)
		`CHK("plain service", 1'b1, service_irq)
		`CHK("plain push", 1'b1, cc_push)
		@(posedge clk_sys);
		halt_wake_irq <= 1'b0;
		// not timed (bit2 set): halt with option gives watchdog reset
		watchdog_halt_option <= 1'b1;
		{overflow_irq_enable, timer_select_bit2, timer_clock_select0} <= '1;
		do_halt();
		`CHK("watchdog reset", 1'b1, watchdog_reset)
		`CHK("no halt", 1'b1, cpu_run)
		// timed halt by timebase enable, woken by timer interrupt
		@(posedge clk_sys);
		timebase_irq_enable <= 1'b1;
		do_halt();
		`CHK("timed no reset", 1'b0, watchdog_reset)
		`CHK("timed mask", 1'b0, irq_mask)
		`CHK("timed osc", 1'b1, main_osc_en)
		`CHK("timed timer", 1'b1, timer_clk_en)
		`CHK("timed periph", 1'b0, periph_clk_en)
		@(posedge clk_sys);
		active_wake_irq <= 1'b1;
		wait_hi(W_RUN, 4, cyc);
		`CHK("timed fast exit", 1'b1, cyc <= 2)
		`CHK("timed service", 1'b1, service_irq)
		@(posedge clk_sys);
		active_wake_irq <= 1'b0;
		// timed halt by overflow path, ended by reset
		timebase_irq_enable <= 1'b0;
		timer_select_bit2   <= 1'b0;
		do_halt();
		`CHK("overflow timed", 1'b1, timer_clk_en)
		`CHK("overflow halted", 1'b0, cpu_run)
		@(posedge clk_sys);
		wake_reset <= 1'b1;
		wait_hi(W_FETCH, 400, cyc);
		`CHK("reset exit delay", 1'b1, cyc >= 256 && cyc <= 259)
		@(posedge clk_sys);
		wake_reset <= 1'b0;
		// auto-wake beats timed halt; smallest prescaler
		watchdog_active     <= 1'b0;
		timebase_irq_enable <= 1'b1;
		apb(1'b1, ADDR_PRESCALER, 32'h00000001, d);
		apb(1'b1, ADDR_CTRL_STAT, 32'h00000001, d);
		do_halt();
		`CHK("awu state", 1'b1, auto_wake_halt_state)
		`CHK("awu osc", 1'b0, main_osc_en)
		`CHK("awu periph", 1'b0, periph_clk_en)
		`CHK("awu rc", 1'b1, rc_osc_en)
		wait_hi(W_FLAG, 2000, cyc);
		`CHK("awu delay", 1'b1, cyc >= 64 * RC_PER && cyc <= 68 * RC_PER)
		wait_hi(W_RUN, 400, cyc);
		`CHK("awu stab", 1'b1, cyc >= 255 && cyc <= 259)
		`CHK("awu service", 1'b1, service_irq)
		apb(1'b0, ADDR_CTRL_STAT, 32'h0, d);
		`CHK("flag read", 32'h00000005, d)
		apb(1'b0, ADDR_CTRL_STAT, 32'h0, d);
		`CHK("flag cleared", 32'h00000001, d)
		`CHK("awu irq cleared", 1'b0, auto_wake_irq)
		// auto-wake halt with long delay left early by an interrupt
		apb(1'b1, ADDR_PRESCALER, 32'h000000FF, d);
		do_halt();
		@(posedge clk_sys);
		halt_wake_irq <= 1'b1;
		wait_hi(W_RUN, 400, cyc);
		`CHK("awu irq exit", 1'b1, cyc >= 256 && cyc <= 259)
		@(posedge clk_sys);
		halt_wake_irq <= 1'b0;
		// measurement in run: capture follows the rc ticks
		apb(1'b1, ADDR_CTRL_STAT, 32'h00000002, d);
		repeat (8) begin
			@(posedge clk_sys);
			#1;
			`CHK("capture", rc_tick, capture_in)
		end
		results();
	end
endmodule : tb_halt_mode_wakeup_controller
`default_nettype wire
